// >>> include/tick_pkg.sv
// package of register map, field layout and constants for the periodic tick counter
package tick_pkg;
    localparam logic [31:0] OFFS_STATUS_CONTROL = 32'h0000_0000;
    localparam logic [31:0] OFFS_COUNT = 32'h0000_0004;
    localparam logic [31:0] OFFS_MATCH_LIMIT = 32'h0000_0008;
    localparam logic [31:0] OFFS_IRQ_STATUS = 32'h0000_000C;
    localparam logic [31:0] OFFS_IRQ_MASK = 32'h0000_0010;

    localparam int FLAG_BIT = 7;
    localparam int SRC_HI = 6;
    localparam int SRC_LO = 5;
    localparam int IRQEN_BIT = 4;
    localparam int DIV_HI = 3;
    localparam int DIV_LO = 0;

    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] LIMIT_RESET = 8'h00;
    localparam logic [3:0] DIV_OFF = 4'h0;
    localparam logic [1:0] SRC_LPO = 2'h0;
    localparam logic [1:0] SRC_EXT = 2'h1;

    // irq status/mask bit positions
    localparam int EVT_MATCH = 0;
    localparam int EVT_TICK = 1;
    localparam int EVT_W = 2;

    localparam int PRE_W = 18;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic flag;
        logic [1:0] source;
        logic irqEnable;
        logic [3:0] divider;
    } control_t;

    typedef struct packed {
        logic [31:0] addr;
        logic write;
    } access_t;

    typedef enum {SRC_STATE_LPO, SRC_STATE_EXT, SRC_STATE_INT} src_state_t;
endpackage : tick_pkg

// >>> src/tick_prescaler.sv
// prescaler: synchronises the chosen source and divides its rising edges
`timescale 1ns/1ps
module tick_prescaler (
    input wire logic clk_sys, // system clock
    input wire logic rst, // async reset, high
    input wire logic srcLpo, // 1 kHz low-power oscillator
    input wire logic srcExt, // external reference clock
    input wire logic srcInt, // internal reference clock
    input wire logic [1:0] source, // tick source select
    input wire logic [3:0] divider, // divider select
    input wire logic clear, // reset prescaler count
    input wire logic freeze, // hold counting
    output logic tick // one-cycle prescaler output pulse
);
    logic [2:0] syncA [3];
    logic level [3]; // one element per source, each driven by its own process
    logic lastLevel [3];
    logic [tick_pkg::PRE_W-1:0] preCount;
    logic [tick_pkg::PRE_W-1:0] ratio;
    logic selLevel;
    logic selLast;

    // three-stage synchroniser per source; a change counts once stages 2 and 3 agree
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    syncA[g] <= 3'h0;
                    level[g] <= 1'b0;
                    lastLevel[g] <= 1'b0;
                end else begin
                    syncA[g] <= {syncA[g][1:0], (g == 0) ? srcLpo : (g == 1) ? srcExt : srcInt};
                    if (syncA[g][1] == syncA[g][2]) begin
                        level[g] <= syncA[g][2];
                    end
                    lastLevel[g] <= level[g];
                end
            end
        end
    endgenerate

    // source mux
    always_comb begin
        case (source)
            tick_pkg::SRC_LPO: begin
                selLevel = level[0];
                selLast = lastLevel[0];
            end
            tick_pkg::SRC_EXT: begin
                selLevel = level[1];
                selLast = lastLevel[1];
            end
            default: begin
                selLevel = level[2];
                selLast = lastLevel[2];
            end
        endcase
    end

    // divide ratio table
    always_comb begin
        ratio = 18'h00001;
        if (!source[0]) begin
            case (divider)
                4'h1: ratio = 18'h00008;
                4'h2: ratio = 18'h00020;
                4'h3: ratio = 18'h00040;
                4'h4: ratio = 18'h00080;
                4'h5: ratio = 18'h00100;
                4'h6: ratio = 18'h00200;
                4'h7: ratio = 18'h00400;
                4'h8: ratio = 18'h00001;
                4'h9: ratio = 18'h00002;
                4'hA: ratio = 18'h00004;
                4'hB: ratio = 18'h0000A;
                4'hC: ratio = 18'h00010;
                4'hD: ratio = 18'h00064;
                4'hE: ratio = 18'h001F4;
                4'hF: ratio = 18'h003E8;
                default: ratio = 18'h00001;
            endcase
        end else begin
            case (divider)
                4'h1: ratio = 18'h00400;
                4'h2: ratio = 18'h00800;
                4'h3: ratio = 18'h01000;
                4'h4: ratio = 18'h02000;
                4'h5: ratio = 18'h04000;
                4'h6: ratio = 18'h08000;
                4'h7: ratio = 18'h10000;
                4'h8: ratio = 18'h003E8;
                4'h9: ratio = 18'h007D0;
                4'hA: ratio = 18'h01388;
                4'hB: ratio = 18'h02710;
                4'hC: ratio = 18'h04E20;
                4'hD: ratio = 18'h0C350;
                4'hE: ratio = 18'h186A0;
                4'hF: ratio = 18'h30D40;
                default: ratio = 18'h00001;
            endcase
        end
    end

    // count source rising edges; emit tick every ratio edges
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            preCount <= '0;
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (clear) begin
                preCount <= '0;
            end else if (divider != tick_pkg::DIV_OFF && !freeze && selLevel && !selLast) begin
                if (preCount + 18'h00001 >= ratio) begin
                    preCount <= '0;
                    tick <= 1'b1;
                end else begin
                    preCount <= preCount + 18'h00001;
                end
            end
        end
    end
endmodule : tick_prescaler

// >>> src/periodic_tick_counter.sv
// periodic tick counter with AHB-Lite register slave and match interrupt
`timescale 1ns/1ps
module periodic_tick_counter (
    input wire logic clk_sys, // system clock 50 MHz
    input wire logic rst, // async reset, high
    input wire logic hsel, // AHB slave select
    input wire logic [31:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hready, // AHB bus ready
    output logic [31:0] hrdata, // AHB read data
    output logic hreadyout, // AHB slave ready
    output logic hresp, // AHB response, always OKAY
    input wire logic lowPowerOsc, // 1 kHz low-power oscillator
    input wire logic externalRefClock, // external reference clock
    input wire logic internalRefClock, // internal reference clock
    input wire logic debugActive, // background debug mode active
    output logic irq, // match interrupt request, level
    output logic irqCombined // masked event interrupt, level
);
    tick_pkg::control_t ctrl;
    logic [7:0] tickCount;
    logic [7:0] matchLimit;
    logic [tick_pkg::EVT_W-1:0] evtStatus;
    logic [tick_pkg::EVT_W-1:0] evtMask;
    tick_pkg::access_t pend;
    logic pendValid;
    logic tick;
    logic clearCount;
    logic matchEvent;
    logic wrCtrl;
    logic wrLimit;
    logic wrStatus;
    logic wrMask;
    logic [2:0] dbgSync;
    logic dbgHold;
    logic [tick_pkg::EVT_W-1:0] evtSet;
    logic [31:0] next_hrdata;

    // AHB address phase capture; the slave never stalls
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pendValid <= 1'b0;
            pend <= '0;
        end else if (hready) begin
            pendValid <= hsel && htrans == tick_pkg::HTRANS_NONSEQ;
            pend.addr <= haddr;
            pend.write <= hwrite;
        end
    end

    // data phase write strobes
    assign wrCtrl = pendValid && pend.write && pend.addr == tick_pkg::OFFS_STATUS_CONTROL;
    assign wrLimit = pendValid && pend.write && pend.addr == tick_pkg::OFFS_MATCH_LIMIT;
    assign wrStatus = pendValid && pend.write && pend.addr == tick_pkg::OFFS_IRQ_STATUS;
    assign wrMask = pendValid && pend.write && pend.addr == tick_pkg::OFFS_IRQ_MASK;

    // ready and response are constant after reset
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // debug level synchroniser, stages 2 and 3 must agree
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dbgSync <= 3'h0;
            dbgHold <= 1'b0;
        end else begin
            dbgSync <= {dbgSync[1:0], debugActive};
            if (dbgSync[1] == dbgSync[2]) begin
                dbgHold <= dbgSync[2];
            end
        end
    end

    // clear on changed selects or any limit write
    assign clearCount = wrLimit
        || (wrCtrl && (hwdata[tick_pkg::SRC_HI:tick_pkg::SRC_LO] != ctrl.source
        || hwdata[tick_pkg::DIV_HI:tick_pkg::DIV_LO] != ctrl.divider));

    tick_prescaler u_prescaler (
        .clk_sys(clk_sys),
        .rst(rst),
        .srcLpo(lowPowerOsc),
        .srcExt(externalRefClock),
        .srcInt(internalRefClock),
        .source(ctrl.source),
        .divider(ctrl.divider),
        .clear(clearCount),
        .freeze(dbgHold),
        .tick(tick)
    );

    assign matchEvent = tick && !clearCount && tickCount == matchLimit;

    // control fields and sticky match flag
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl <= '0;
        end else begin
            if (wrCtrl) begin
                ctrl.source <= hwdata[tick_pkg::SRC_HI:tick_pkg::SRC_LO];
                ctrl.irqEnable <= hwdata[tick_pkg::IRQEN_BIT];
                ctrl.divider <= hwdata[tick_pkg::DIV_HI:tick_pkg::DIV_LO];
            end
            if (matchEvent) begin
                ctrl.flag <= 1'b1;
            end else if (wrCtrl && hwdata[tick_pkg::FLAG_BIT]) begin
                ctrl.flag <= 1'b0;
            end
        end
    end

    // tick counter
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tickCount <= tick_pkg::COUNT_RESET;
        end else if (clearCount) begin
            tickCount <= tick_pkg::COUNT_RESET;
        end else if (matchEvent) begin
            tickCount <= tick_pkg::COUNT_RESET;
        end else if (tick) begin
            tickCount <= tickCount + 8'h01;
        end
    end

    // match limit; the count register has no write path
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            matchLimit <= tick_pkg::LIMIT_RESET;
        end else if (wrLimit) begin
            matchLimit <= hwdata[7:0];
        end
    end

    // event status, write one to clear, set wins
    assign evtSet = {tick && !clearCount, matchEvent};
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            evtStatus <= '0;
            evtMask <= '0;
        end else begin
            if (wrMask) begin
                evtMask <= hwdata[tick_pkg::EVT_W-1:0];
            end
            if (wrStatus) begin
                evtStatus <= (evtStatus & ~hwdata[tick_pkg::EVT_W-1:0]) | evtSet;
            end else begin
                evtStatus <= evtStatus | evtSet;
            end
        end
    end

    // interrupt outputs, registered
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
            irqCombined <= 1'b0;
        end else begin
            irq <= ctrl.irqEnable && (matchEvent || (ctrl.flag
                && !(wrCtrl && hwdata[tick_pkg::FLAG_BIT])));
            irqCombined <= |((evtStatus | evtSet) & evtMask);
        end
    end

    // read mux for the address phase being accepted
    always_comb begin
        next_hrdata = 32'h0000_0000;
        case (haddr)
            tick_pkg::OFFS_STATUS_CONTROL: next_hrdata = {24'h000000, ctrl};
            tick_pkg::OFFS_COUNT: next_hrdata = {24'h000000, tickCount};
            tick_pkg::OFFS_MATCH_LIMIT: next_hrdata = {24'h000000, matchLimit};
            tick_pkg::OFFS_IRQ_STATUS: next_hrdata = {30'h00000000, evtStatus};
            tick_pkg::OFFS_IRQ_MASK: next_hrdata = {30'h00000000, evtMask};
            default: next_hrdata = 32'h0000_0000;
        endcase
    end

    // read data registered at the address phase edge, valid through data phase
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans == tick_pkg::HTRANS_NONSEQ && !hwrite) begin
            hrdata <= next_hrdata;
        end
    end
endmodule : periodic_tick_counter

// >>> testbench/tick_monitor.sv
// checker of bus answers and interrupt levels of the periodic tick counter
`timescale 1ns/1ps
module tick_monitor (
    input wire logic clk_sys, // clock
    input wire logic rst, // reset
    input wire logic hsel, // select
    input wire logic [31:0] haddr, // address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    input wire logic [31:0] hrdata, // read data
    input wire logic hreadyout, // slave ready
    input wire logic hresp, // response
    input wire logic irq, // match request
    input wire logic irqCombined // event request
);
    logic take;
    logic pendWr;
    logic [31:0] pendAddr;
    logic [6:0] ctl;
    logic [1:0] mask;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // accepted address phase
    assign take = hsel && hready && htrans == tick_pkg::HTRANS_NONSEQ;
    // shadows of control fields and event mask, kept from completed writes
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pendWr <= 1'b0;
            pendAddr <= 32'h0;
            ctl <= 7'h00;
            mask <= 2'h0;
        end else if (hready) begin
            pendWr <= take && hwrite;
            pendAddr <= haddr;
            if (pendWr && pendAddr == tick_pkg::OFFS_STATUS_CONTROL) ctl <= hwdata[6:0];
            if (pendWr && pendAddr == tick_pkg::OFFS_IRQ_MASK) mask <= hwdata[1:0];
        end
    end
    a_bus_okay:
        assert property (hreadyout && !hresp) else $error("bus answer not ready or not okay");
    a_read_upper:
        assert property (take && !hwrite |=> hrdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_unmapped_zero:
        assert property (take && !hwrite && haddr > tick_pkg::OFFS_IRQ_MASK |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_hrdata_hold:
        assert property (!(take && !hwrite) |=> $stable(hrdata)) else $error("read data moved");
    a_status_readback:
        assert property (take && !hwrite && haddr == tick_pkg::OFFS_STATUS_CONTROL
            |=> hrdata[6:0] == $past(ctl)) else $error("control fields read back wrong");
    a_irq_disabled:
        assert property (!ctl[4] [*3] |-> !irq) else $error("request while disabled");
    a_events_masked:
        assert property (mask == 2'h0 [*3] |-> !irqCombined) else $error("masked event request");
    a_flag_clear:
        assert property (pendWr && hready && pendAddr == tick_pkg::OFFS_STATUS_CONTROL
            && hwdata[7] && hwdata[3:0] == 4'h0 |-> ##[1:3] !irq) else $error("request kept");
endmodule : tick_monitor
bind periodic_tick_counter tick_monitor mon_u (.clk_sys, .rst, .hsel, .haddr, .htrans,
    .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .irq, .irqCombined);

// >>> testbench/periodic_tick_counter_tb.sv
// self-checking bench of the periodic tick counter
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin mismatches++; \
    $display("unexpected %s exp %h got %h", nm, ex, got); end end
module periodic_tick_counter_tb;
    typedef struct packed {logic [31:0] val; logic [31:0] care;} note_t;
    localparam logic [31:0] SC = tick_pkg::OFFS_STATUS_CONTROL;
    localparam logic [31:0] CNT = tick_pkg::OFFS_COUNT;
    localparam logic [31:0] LIM = tick_pkg::OFFS_MATCH_LIMIT;
    localparam int SETTLE = 10;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [2:0] srcs = 3'h0;
    logic dbg = 1'b0;
    logic rdPhase = 1'b0;
    logic pinReq = 1'b0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic irq;
    logic irqCombined;
    logic [31:0] seed = 32'h0D3E7FB9;
    int mismatches = 0;
    int checks_done = 0;
    note_t notes[$];
    note_t cur;
    int tSrc[7] = '{0, 0, 0, 0, 2, 1, 0};
    int tCode[7] = '{8, 9, 1, 11, 10, 8, 0};
    int tPulse[7] = '{5, 6, 16, 20, 8, 1000, 4};
    int tExp[7] = '{5, 3, 2, 2, 2, 1, 0};
    periodic_tick_counter dut_u (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .lowPowerOsc(srcs[0]),
        .externalRefClock(srcs[1]), .internalRefClock(srcs[2]), .debugActive(dbg),
        .irq(irq), .irqCombined(irqCombined));
    // 50 MHz clock
    initial forever #10 clk_sys = ~clk_sys;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic close_out();
        if (mismatches == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out
    // one single word transfer: address phase, then data phase
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= tick_pkg::HTRANS_NONSEQ;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
    endtask : xfer
    task automatic rd(input logic [31:0] a, input logic [31:0] v);
        notes.push_back('{v, 32'hFFFF_FFFF});
        xfer(a, 1'b0, 32'h0);
    endtask : rd
    // probe of {irqCombined, irq}
    task automatic pins(input logic [1:0] v);
        notes.push_back('{{30'h0, v}, 32'h3});
        @(posedge clk_sys);
        pinReq <= 1'b1;
        @(posedge clk_sys);
        pinReq <= 1'b0;
    endtask : pins
    // whole periods of one source clock, each level held four cycles
    task automatic pulse(input int idx, input int n);
        repeat (n) begin
            srcs[idx] <= 1'b1;
            repeat (4) @(posedge clk_sys);
            srcs[idx] <= 1'b0;
            repeat (4) @(posedge clk_sys);
        end
        repeat (SETTLE) @(posedge clk_sys);
    endtask : pulse
    // compares every finished read or probe with the oldest note
    always @(posedge clk_sys) begin
        if (rdPhase || pinReq) begin
            cur = notes.pop_front();
            `CHK(rdPhase ? "hrdata" : "irq pins", cur.val & cur.care,
                (rdPhase ? hrdata : {30'h0, irqCombined, irq}) & cur.care)
        end
        rdPhase <= hsel && htrans == tick_pkg::HTRANS_NONSEQ && !hwrite && hreadyout;
    end
    // hang guard
    initial begin
        repeat (60000) @(posedge clk_sys);
        mismatches++;
        close_out();
    end
    // main sequence
    initial begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rd(SC, 32'h0);
        rd(CNT, 32'h0);
        rd(LIM, 32'h0);
        pins(2'h0);
        xfer(CNT, 1'b1, 32'hFF);
        rd(CNT, 32'h0);
        rd(32'h40, 32'h0);
        for (int i = 0; i < 7; i++) begin
            xfer(SC, 1'b1, {25'h0, tSrc[i][1:0], 1'b0, tCode[i][3:0]});
            xfer(LIM, 1'b1, 32'hFF);
            pulse(tSrc[i] > 1 ? 2 : tSrc[i], tPulse[i]);
            rd(CNT, tExp[i]);
        end
        xfer(SC, 1'b1, 32'h18);
        xfer(LIM, 1'b1, 32'h3);
        pulse(0, 3);
        rd(CNT, 32'h3);
        rd(SC, 32'h18);
        pulse(0, 1);
        rd(CNT, 32'h0);
        rd(SC, 32'h98);
        pins(2'h1);
        xfer(SC, 1'b1, 32'h18);
        rd(SC, 32'h98);
        pulse(0, 2);
        rd(CNT, 32'h2);
        xfer(tick_pkg::OFFS_IRQ_MASK, 1'b1, 32'h1);
        pins(2'h3);
        xfer(tick_pkg::OFFS_IRQ_STATUS, 1'b1, 32'h3);
        pins(2'h1);
        xfer(SC, 1'b1, 32'h90);
        rd(SC, 32'h10);
        rd(CNT, 32'h0);
        pins(2'h0);
        xfer(SC, 1'b1, 32'h08);
        xfer(LIM, 1'b1, 32'h0);
        pulse(0, 1);
        rd(SC, 32'h88);
        rd(CNT, 32'h0);
        pins(2'h2);
        repeat (4) begin
            seed = lfsr(seed);
            pulse(0, 2);
            xfer(LIM, 1'b1, {24'h0, seed[7:0]});
            rd(LIM, {24'h0, seed[7:0]});
            rd(CNT, 32'h0);
        end
        xfer(LIM, 1'b1, 32'hFF);
        pulse(0, 3);
        dbg <= 1'b1;
        repeat (SETTLE) @(posedge clk_sys);
        pulse(0, 4);
        rd(CNT, 32'h3);
        dbg <= 1'b0;
        repeat (SETTLE) @(posedge clk_sys);
        pulse(0, 2);
        rd(CNT, 32'h5);
        repeat (4) @(posedge clk_sys);
        close_out();
    end
endmodule : periodic_tick_counter_tb
